/* design/eecp_consts.vh */
`ifndef EECP_CONSTS_VH
`define EECP_CONSTS_VH
// ------------------------------------------------------------
// address map
// ------------------------------------------------------------
`define EECP_ARR_BASE     16'h0800
`define EECP_ARR_LAST     16'h09ff
`define EECP_A_NV_DIVH    16'hfe10
`define EECP_A_NV_DIVL    16'hfe11
`define EECP_A_DIVH       16'hfe1a
`define EECP_A_DIVL       16'hfe1b
`define EECP_A_NV_CFG     16'hfe1c
`define EECP_A_CTRL       16'hfe1d
`define EECP_A_ACR        16'hfe1f
// ------------------------------------------------------------
// fields
// ------------------------------------------------------------
`define EECP_CFG_ARM      4
`define EECP_DIVH_LOCK    7
`define EECP_CTL_START    0
`define EECP_CTL_AUTO     1
`define EECP_CTL_LATCH    2
`define EECP_CTL_MODE_LO  3
`define EECP_CTL_MODE_HI  4
`define EECP_CTL_OFF      5
`define EECP_CTL_REFUSED  6
`define EECP_SEC_BLK16    5'h0f
// ------------------------------------------------------------
// modes, targets, reset values, timing
// ------------------------------------------------------------
`define EECP_M_PROG       2'h0
`define EECP_M_BYTE_ERASE 2'h1
`define EECP_M_BLK_ERASE  2'h2
`define EECP_M_BULK_ERASE 2'h3
`define EECP_T_ARRAY      2'h0
`define EECP_T_NV_CFG     2'h1
`define EECP_T_NV_DIVH    2'h2
`define EECP_T_NV_DIVL    2'h3
`define EECP_ERASED       8'hff
`define EECP_RST_CTRL     8'h00
`define EECP_RST_ACR      5'h1f
`define EECP_RST_DIVH     8'h87
`define EECP_TIMEBASE_US  35
`define EECP_PE_TICKS     8'h08
`endif

/* design/eecp_tbdiv.v */
`timescale 1ns/1ps
module eecp_tbdiv (
   // clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // reference
   input  wire        ref_tick,
   input  wire [15:0] div,
   // timebase out
   output wire        tb_tick
);
   reg  [15:0] cnt_ff;
   wire        wrap;

   // zero divider stops the timebase: no tick at all
   assign wrap    = ref_tick && (div != 16'h0000) && (cnt_ff >= div - 16'h0001);
   assign tb_tick = wrap;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 16'h0000;
      end else if (wrap) begin
         cnt_ff <= 16'h0000;
      end else if (ref_tick) begin
         cnt_ff <= cnt_ff + 16'h0001;
      end
   end
endmodule // eecp_tbdiv

/* design/eecp_guard.v */
`timescale 1ns/1ps
`include "eecp_consts.vh"
module eecp_guard (
   // target
   input  wire [1:0] kind,
   input  wire [8:0] off,
   input  wire [1:0] mode,
   // protection state
   input  wire       armed,
   input  wire       div_locked,
   input  wire [3:0] bp,
   // verdict
   output reg        allow
);
   wire secure = (off[8:4] == `EECP_SEC_BLK16);
   wire blk_bp = bp[off[8:7]];
   wire single = (mode == `EECP_M_PROG) || (mode == `EECP_M_BYTE_ERASE);

   always @* begin
      allow = 1'b0;
      case (kind)
         `EECP_T_ARRAY: begin
            if (single) begin
               allow = !blk_bp && !(armed && secure);
            end else if (mode == `EECP_M_BLK_ERASE) begin
               allow = !armed && !blk_bp;
            end else begin
               // bulk refused if any block is protected, rather than erasing around it
               allow = !armed && (bp == 4'h0);
            end
         end
         `EECP_T_NV_CFG: begin
            allow = single && !armed;
         end
         default: begin
            allow = single && !div_locked;
         end
      endcase
   end
endmodule // eecp_guard

/* design/eecp_top.v */
// Behaviour
// - array is 512 bytes at 0800h..09FFh
// - config and divider cells use array mechanism
// - reset copies nonvolatile registers into shadows
// - config byte and divider bytes load shadows
// - 35 us timebase from selectable reference
// - armed protection freezes secured bytes 08F0h..08FFh
// - secured bytes still read normally
// - armed protection freezes nonvolatile config byte
// - armed protection refuses block and bulk erase
// - armed still allows unprotected single bytes
// - four 128-byte blocks with protect bits
// - block select from address bits 8:7
// - protect bits reload on reset or read
// - programmed divider lock reloads zero always
// - divider lock freezes divider cells and shadows
// - erased reads one; program clears, erase sets
`timescale 1ns/1ps
`include "eecp_consts.vh"
module eecp_top #(
   parameter [7:0] PE_TICKS = `EECP_PE_TICKS
) (
   // clock and resets
   input  wire        clk,
   input  wire        rst_n,
   input  wire        por_n,
   // avalon-mm slave
   input  wire [15:0] address,
   input  wire        read,
   input  wire        write,
   input  wire [7:0]  writedata,
   output wire [7:0]  readdata,
   output wire        waitrequest,
   // timebase reference
   input  wire        timebase_clock_select,
   input  wire        oscillator_ref_clock,
   // charge pump
   output wire        pump_on
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   // nonvolatile cells, cleared only by power-on reset
   reg  [7:0] mem [0:511];
   reg  [7:0] nv_array_config_byte_ff;
   reg  [7:0] nv_divider_high_byte_ff;
   reg  [7:0] nv_divider_low_byte_ff;

   // volatile shadows
   reg  [4:0] array_config_shadow_ff;
   reg  [7:0] divider_high_shadow_ff;
   reg  [7:0] divider_low_shadow_ff;

   // bus answer
   reg        load_pend_ff;
   reg        wait_ff;
   reg  [7:0] rdata_ff;

   // control register
   reg        start_ff;
   reg        auto_ff;
   reg        latch_ff;
   reg  [1:0] mode_ff;
   reg        off_ff;
   reg        refused_ff;

   // latch and timer
   reg        lat_valid_ff;
   reg  [1:0] lat_kind_ff;
   reg  [8:0] lat_off_ff;
   reg  [7:0] lat_data_ff;
   reg  [7:0] pe_cnt_ff;
   reg        pump_on_ff;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   wire       take    = (read || write) && wait_ff && !load_pend_ff;
   wire       wr      = take && write;
   wire       rd      = take && read;
   wire       in_arr  = (address >= `EECP_ARR_BASE) && (address <= `EECP_ARR_LAST);
   wire [8:0] arr_off = address[8:0];
   wire       is_nvh  = (address == `EECP_A_NV_DIVH);
   wire       is_nvl  = (address == `EECP_A_NV_DIVL);
   wire       is_nvc  = (address == `EECP_A_NV_CFG);
   wire       is_ctl  = (address == `EECP_A_CTRL);

   // ------------------------------------------------------------
   // protection state
   // ------------------------------------------------------------
   // arming acts at once from the cell, the shadow keeps it after reset
   wire       armed      = !nv_array_config_byte_ff[`EECP_CFG_ARM] ||
                           !array_config_shadow_ff[`EECP_CFG_ARM];
   // lock follows the shadow only, so a freshly programmed lock waits for reset
   wire       div_locked = !divider_high_shadow_ff[`EECP_DIVH_LOCK];
   // a set bit protects its block; erased cells protect every block
   wire [3:0] bp         = array_config_shadow_ff[3:0];

   // a start write may carry a new mode, and that mode is the one that runs;
   // judging the old one would let a bulk erase slip past an armed guard
   wire       ctl_new    = wr && is_ctl && !start_ff;
   wire [1:0] want_mode  = ctl_new ? writedata[`EECP_CTL_MODE_HI:`EECP_CTL_MODE_LO] : mode_ff;

   // ------------------------------------------------------------
   // protection guard
   // ------------------------------------------------------------
   wire allow;
   eecp_guard u_guard (
      .kind       (lat_kind_ff),
      .off        (lat_off_ff),
      .mode       (want_mode),
      .armed      (armed),
      .div_locked (div_locked),
      .bp         (bp),
      .allow      (allow)
   );

   // ------------------------------------------------------------
   // timebase
   // ------------------------------------------------------------
   // bus clock means every system clock is a reference edge
   wire        ref_tick = timebase_clock_select ? 1'b1 : oscillator_ref_clock;
   wire [15:0] div_val  = {5'h00, divider_high_shadow_ff[2:0], divider_low_shadow_ff};
   wire        tb_tick;
   eecp_tbdiv u_tbdiv (
      .clk      (clk),
      .rst_n    (rst_n),
      .ref_tick (ref_tick),
      .div      (div_val),
      .tb_tick  (tb_tick)
   );

   // ------------------------------------------------------------
   // operation sequencing
   // ------------------------------------------------------------
   wire ctl_wr      = wr && is_ctl;
   wire want_start  = ctl_wr && writedata[`EECP_CTL_START] && !start_ff;
   wire start_ok    = want_start && latch_ff && lat_valid_ff && allow;
   wire start_bad   = want_start && !(latch_ff && lat_valid_ff && allow);
   wire auto_done   = start_ff && auto_ff && tb_tick && (pe_cnt_ff == PE_TICKS - 8'h01);
   wire manual_done = start_ff && !auto_ff && ctl_wr && !writedata[`EECP_CTL_START];
   // cells change only when an operation ends, never at its start
   wire op_apply    = auto_done || manual_done;
   // only mapped cells latch; the last valid write before start wins
   wire lat_wr      = wr && latch_ff && !start_ff && (in_arr || is_nvh || is_nvl || is_nvc);

   // ------------------------------------------------------------
   // nonvolatile array, one cell per entry
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 512; gi = gi + 1) begin : g_cell
         localparam [31:0] cell_idx = gi;
         wire [8:0]        me       = cell_idx[8:0];
         wire       hit = op_apply && (lat_kind_ff == `EECP_T_ARRAY) &&
                          ((mode_ff == `EECP_M_BULK_ERASE) ||
                           ((mode_ff == `EECP_M_BLK_ERASE) &&
                            (lat_off_ff[8:7] == me[8:7])) ||
                           (lat_off_ff == me));
         always @(posedge clk or negedge por_n) begin
            if (!por_n) begin
               mem[gi] <= `EECP_ERASED;
            end else if (hit) begin
               if (mode_ff == `EECP_M_PROG) begin
                  mem[gi] <= mem[gi] & lat_data_ff;
               end else begin
                  mem[gi] <= `EECP_ERASED;
               end
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // nonvolatile configuration cells
   // ------------------------------------------------------------
   // same program/erase path as array bytes, only single-byte modes
   wire [7:0] nv_next_cfg = (mode_ff == `EECP_M_PROG) ?
                            (nv_array_config_byte_ff & lat_data_ff) : `EECP_ERASED;
   wire [7:0] nv_next_dh  = (mode_ff == `EECP_M_PROG) ?
                            (nv_divider_high_byte_ff & lat_data_ff) : `EECP_ERASED;
   wire [7:0] nv_next_dl  = (mode_ff == `EECP_M_PROG) ?
                            (nv_divider_low_byte_ff & lat_data_ff) : `EECP_ERASED;

   always @(posedge clk or negedge por_n) begin
      if (!por_n) begin
         nv_array_config_byte_ff <= `EECP_ERASED;
         nv_divider_high_byte_ff <= `EECP_ERASED;
         nv_divider_low_byte_ff  <= `EECP_ERASED;
      end else if (op_apply) begin
         if (lat_kind_ff == `EECP_T_NV_CFG) begin
            nv_array_config_byte_ff <= nv_next_cfg;
         end
         if (lat_kind_ff == `EECP_T_NV_DIVH) begin
            nv_divider_high_byte_ff <= nv_next_dh;
         end
         if (lat_kind_ff == `EECP_T_NV_DIVL) begin
            nv_divider_low_byte_ff <= nv_next_dl;
         end
      end
   end

   // ------------------------------------------------------------
   // volatile shadows
   // ------------------------------------------------------------
   // async reset may only load constants, so the copy happens on
   // the first clock after release; the bus is held off until then
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         load_pend_ff           <= 1'b1;
         array_config_shadow_ff <= `EECP_RST_ACR;
         divider_high_shadow_ff <= `EECP_RST_DIVH;
         divider_low_shadow_ff  <= `EECP_ERASED;
      end else if (load_pend_ff) begin
         load_pend_ff           <= 1'b0;
         array_config_shadow_ff <= nv_array_config_byte_ff[4:0];
         divider_high_shadow_ff <= {nv_divider_high_byte_ff[`EECP_DIVH_LOCK], 4'h0,
                                    nv_divider_high_byte_ff[2:0]};
         divider_low_shadow_ff  <= nv_divider_low_byte_ff;
      end else begin
         if (rd && is_nvc) begin
            array_config_shadow_ff[3:0] <= nv_array_config_byte_ff[3:0];
         end
         if (wr && (address == `EECP_A_DIVH) && !div_locked) begin
            // lock bit may be cleared by software but never set back
            divider_high_shadow_ff <= {divider_high_shadow_ff[`EECP_DIVH_LOCK] &
                                       writedata[`EECP_DIVH_LOCK], 4'h0,
                                       writedata[2:0]};
         end
         if (wr && (address == `EECP_A_DIVL) && !div_locked) begin
            divider_low_shadow_ff <= writedata;
         end
      end
   end

   // ------------------------------------------------------------
   // control register, latch and timer
   // ------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start_ff     <= 1'b0;
         auto_ff      <= 1'b0;
         latch_ff     <= 1'b0;
         mode_ff      <= `EECP_M_PROG;
         off_ff       <= 1'b0;
         refused_ff   <= 1'b0;
         lat_valid_ff <= 1'b0;
         lat_kind_ff  <= `EECP_T_ARRAY;
         lat_off_ff   <= 9'h000;
         lat_data_ff  <= `EECP_ERASED;
         pe_cnt_ff    <= 8'h00;
         pump_on_ff   <= 1'b0;
      end else begin
         if (ctl_wr) begin
            if (!start_ff) begin
               auto_ff <= writedata[`EECP_CTL_AUTO];
               mode_ff <= writedata[`EECP_CTL_MODE_HI:`EECP_CTL_MODE_LO];
               off_ff  <= writedata[`EECP_CTL_OFF];
            end
            // clearing start and latch together only clears start
            if (!(start_ff && !writedata[`EECP_CTL_START])) begin
               latch_ff <= writedata[`EECP_CTL_LATCH];
               if (!writedata[`EECP_CTL_LATCH]) begin
                  lat_valid_ff <= 1'b0;
               end
            end
         end
         // a refused start in the same write as the clear still sets it
         if (start_bad) begin
            refused_ff <= 1'b1;
         end else if (ctl_wr) begin
            refused_ff <= writedata[`EECP_CTL_REFUSED] & refused_ff;
         end
         if (lat_wr) begin
            lat_valid_ff <= 1'b1;
            lat_data_ff  <= writedata;
            lat_off_ff   <= arr_off;
            lat_kind_ff  <= in_arr ? `EECP_T_ARRAY :
                            is_nvc ? `EECP_T_NV_CFG :
                            is_nvh ? `EECP_T_NV_DIVH : `EECP_T_NV_DIVL;
         end
         // pump runs from the accepted start to the applied end
         if (start_ok) begin
            start_ff   <= 1'b1;
            pump_on_ff <= 1'b1;
            pe_cnt_ff  <= 8'h00;
         end else if (op_apply) begin
            start_ff   <= 1'b0;
            pump_on_ff <= 1'b0;
            pe_cnt_ff  <= 8'h00;
         end else if (start_ff && auto_ff && tb_tick) begin
            pe_cnt_ff <= pe_cnt_ff + 8'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   // array reads show stored cells, never the latched write data
   reg [7:0] rd_mux;
   always @* begin
      rd_mux = 8'h00;
      if (in_arr) begin
         rd_mux = mem[arr_off];
      end else begin
         case (address)
            `EECP_A_NV_DIVH: rd_mux = nv_divider_high_byte_ff;
            `EECP_A_NV_DIVL: rd_mux = nv_divider_low_byte_ff;
            `EECP_A_DIVH:    rd_mux = divider_high_shadow_ff;
            `EECP_A_DIVL:    rd_mux = divider_low_shadow_ff;
            `EECP_A_NV_CFG:  rd_mux = nv_array_config_byte_ff;
            `EECP_A_CTRL:    rd_mux = {1'b0, refused_ff, off_ff, mode_ff,
                                       latch_ff, auto_ff, start_ff};
            `EECP_A_ACR:     rd_mux = {3'h0, array_config_shadow_ff};
            default:         rd_mux = 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // bus answer
   // ------------------------------------------------------------
   // one wait state: request acted on at the edge that drops waitrequest
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_ff  <= 1'b1;
         rdata_ff <= 8'h00;
      end else if (take) begin
         wait_ff  <= 1'b0;
         rdata_ff <= read ? rd_mux : 8'h00;
      end else begin
         wait_ff <= 1'b1;
      end
   end

   assign readdata    = rdata_ff;
   assign waitrequest = wait_ff;
   assign pump_on     = pump_on_ff;
endmodule // eecp_top

/* testbench/eecp_top_props.sv */
`timescale 1ns/1ps
`include "eecp_consts.vh"
module eecp_top_props #(
   parameter [7:0] PE_TICKS = `EECP_PE_TICKS
) (
   // clock and resets
   input wire        clk,
   input wire        rst_n,
   input wire        por_n,
   // avalon-mm slave
   input wire [15:0] address,
   input wire        read,
   input wire        write,
   input wire [7:0]  writedata,
   input wire [7:0]  readdata,
   input wire        waitrequest,
   // timebase reference
   input wire        timebase_clock_select,
   input wire        oscillator_ref_clock,
   // charge pump
   input wire        pump_on
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire start_wr = write && address == `EECP_A_CTRL && writedata[`EECP_CTL_START];
   wire unmapped = address < `EECP_ARR_BASE || (address > `EECP_ARR_LAST && address < 16'hfe00);
   // ------
   // bus handshake
   // ------
   a_wait_one_cycle: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for two cycles");
   a_answer_in_time: assert property ($rose(read || write) |-> ##1 !waitrequest)
      else $error("access not answered after one wait cycle");
   a_idle_no_answer: assert property (!(read || write) |=> waitrequest)
      else $error("answer without a request");
   a_reset_load: assert property ($rose(rst_n) |-> waitrequest ##1 waitrequest)
      else $error("access taken during shadow load");
   a_read_hold: assert property (waitrequest |-> $stable(readdata))
      else $error("readdata changed without an access");
   // ------
   // map and pump
   // ------
   a_unmapped_zero: assert property (!waitrequest && unmapped |-> readdata == 8'h00)
      else $error("unmapped access returned data");
   a_divh_gap: assert property (!waitrequest && read && address == `EECP_A_DIVH
      |-> readdata[6:3] == 4'h0)
      else $error("divider high unused bits not zero");
   a_pump_cause: assert property ($rose(pump_on)
      |-> $past(start_wr, 1) || $past(start_wr, 2) || $past(start_wr, 3))
      else $error("pump started without a start write");
endmodule // eecp_top_props

/* testbench/test_eeprom_config_protection.sv */
`timescale 1ns/1ps
`include "eecp_consts.vh"
module test_eeprom_config_protection;
   typedef struct {
      logic [1:0]  m;
      logic [15:0] a;
      logic [7:0]  d;
      logic        rf;
      logic [15:0] ra;
      logic [7:0]  re;
   } eecp_row_t;
   localparam [1:0] P = `EECP_M_PROG;
   localparam [1:0] E = `EECP_M_BYTE_ERASE;
   localparam [1:0] K = `EECP_M_BLK_ERASE;
   localparam [1:0] B = `EECP_M_BULK_ERASE;
   logic        clk = 1'b0, rst_n = 1'b0, por_n = 1'b0, read = 1'b0, write = 1'b0;
   logic        sel = 1'b1, osc = 1'b0, pump_seen = 1'b0;
   logic [1:0]  osc_cnt = 2'h0;
   logic [15:0] address = 16'h0000;
   logic [7:0]  writedata = 8'h00, q;
   wire  [7:0]  readdata;
   wire         waitrequest, pump_on;
   int          fail_count = 0, n_checks = 0;
   eecp_row_t   rows [17] = '{
      '{P, 16'h0800, 8'h5a, 1'h0, 16'h0800, 8'h5a},
      '{P, 16'h0800, 8'h0f, 1'h0, 16'h0800, 8'h0a},
      '{E, 16'h0800, 8'h00, 1'h0, 16'h0800, 8'hff},
      '{P, 16'h0985, 8'h33, 1'h0, 16'h0985, 8'h33},
      '{K, 16'h0980, 8'h00, 1'h0, 16'h0985, 8'hff},
      '{P, 16'h0900, 8'h11, 1'h0, 16'h0900, 8'h11},
      '{B, 16'h0800, 8'h00, 1'h0, 16'h0900, 8'hff},
      '{P, 16'h08f5, 8'ha5, 1'h0, 16'h08f5, 8'ha5},
      '{P, 16'hfe10, 8'h7f, 1'h0, 16'hfe10, 8'h7f},
      '{P, 16'hfe11, 8'h03, 1'h0, 16'hfe11, 8'h03},
      '{P, 16'hfe1c, 8'hef, 1'h0, 16'hfe1c, 8'he0},
      '{P, 16'h08f5, 8'h00, 1'h1, 16'h08f5, 8'ha5},
      '{E, 16'h08f5, 8'h00, 1'h1, 16'h08f5, 8'ha5},
      '{P, 16'h0810, 8'h3c, 1'h0, 16'h0810, 8'h3c},
      '{K, 16'h0800, 8'h00, 1'h1, 16'h0810, 8'h3c},
      '{B, 16'h0900, 8'h00, 1'h1, 16'h0810, 8'h3c},
      '{P, 16'hfe1c, 8'h00, 1'h1, 16'hfe1c, 8'he0}};

   eecp_top #(.PE_TICKS(8'h02)) i_eecp_top (
      .clk(clk), .rst_n(rst_n), .por_n(por_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .timebase_clock_select(sel),
      .oscillator_ref_clock(osc), .pump_on(pump_on));

   always #50 clk = ~clk;
   // oscillator enable every fourth cycle, slower than the bus clock
   always @(posedge clk) begin
      osc_cnt <= osc_cnt + 2'h1;
      osc <= (osc_cnt == 2'h3);
      if (pump_on === 1'b1) pump_seen <= 1'b1;
   end
   // ------
   // tasks
   // ------
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (waitrequest !== 1'b0) fail_count++;
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task rd(input logic [15:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(q, e);
   endtask
   // latch, write target, start, then poll until the start bit drops
   task op(input logic [1:0] m, input logic [15:0] a, input logic [7:0] d, input logic rf);
      int n;
      bus(1'b1, `EECP_A_CTRL, {3'h0, m, 3'h6});
      bus(1'b1, a, d);
      pump_seen = 1'b0;
      bus(1'b1, `EECP_A_CTRL, {3'h0, m, 3'h7});
      n = 0;
      do begin
         bus(1'b0, `EECP_A_CTRL, 8'h00);
         n++;
      end while (q[0] !== 1'b0 && n < 100);
      chk({5'h00, q[6], q[0], pump_seen}, {5'h00, rf, 1'b0, !rf});
      bus(1'b1, `EECP_A_CTRL, 8'h00);
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ------
   // sequence
   // ------
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      @(posedge clk);
      rd(`EECP_A_ACR, 8'h1f);
      rd(`EECP_A_DIVH, 8'h87);
      rd(`EECP_A_DIVL, 8'hff);
      rd(16'h09ff, 8'hff);
      bus(1'b1, 16'h0a00, 8'h55);
      rd(16'h0a00, 8'h00);
      bus(1'b1, `EECP_A_DIVH, 8'h80);
      bus(1'b1, `EECP_A_DIVL, 8'h03);
      rd(`EECP_A_DIVL, 8'h03);
      $display("reset and map test done");
      // erased config protects every block
      op(P, 16'h0880, 8'h00, 1'b1);
      rd(16'h0880, 8'hff);
      op(P, `EECP_A_NV_CFG, 8'hf0, 1'b0);
      rd(`EECP_A_ACR, 8'h1f);
      rd(`EECP_A_NV_CFG, 8'hf0);
      rd(`EECP_A_ACR, 8'h10);
      $display("block protect test done");
      for (int r = 0; r < 17; r++) begin
         sel <= r[0];
         op(rows[r].m, rows[r].a, rows[r].d, rows[r].rf);
         rd(rows[r].ra, rows[r].re);
         $display("row %0d done", r);
      end
      // start write that swaps in bulk erase after an allowed latch
      bus(1'b1, `EECP_A_CTRL, 8'h06);
      bus(1'b1, 16'h0820, 8'h00);
      bus(1'b1, `EECP_A_CTRL, {3'h0, B, 3'h7});
      rd(`EECP_A_CTRL, 8'h5e);
      rd(16'h0810, 8'h3c);
      rd(16'h08f5, 8'ha5);
      bus(1'b1, `EECP_A_CTRL, 8'h00);
      $display("mode swap test done");
      // manual program; clearing start and latch together keeps latch
      bus(1'b1, `EECP_A_CTRL, 8'h24);
      bus(1'b1, 16'h0820, 8'h81);
      bus(1'b1, `EECP_A_CTRL, 8'h25);
      chk({7'h00, pump_on}, 8'h01);
      rd(`EECP_A_CTRL, 8'h25);
      bus(1'b1, `EECP_A_CTRL, 8'h00);
      chk({7'h00, pump_on}, 8'h00);
      rd(`EECP_A_CTRL, 8'h24);
      rd(16'h0820, 8'h81);
      bus(1'b1, `EECP_A_CTRL, 8'h00);
      rd(`EECP_A_CTRL, 8'h00);
      $display("manual mode test done");
      // divider lock takes hold only through a reset
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(`EECP_A_DIVH, 8'h07);
      rd(`EECP_A_ACR, 8'h00);
      bus(1'b1, `EECP_A_DIVL, 8'h55);
      rd(`EECP_A_DIVL, 8'h03);
      op(P, `EECP_A_NV_DIVL, 8'h00, 1'b1);
      rd(`EECP_A_NV_DIVL, 8'h03);
      $display("divider lock test done");
      summarize;
   end
   initial begin
      #(100 * 20000);
      fail_count++;
      summarize;
   end
endmodule // test_eeprom_config_protection

bind eecp_top eecp_top_props #(.PE_TICKS(PE_TICKS)) i_eecp_top_props (
   .clk(clk), .rst_n(rst_n), .por_n(por_n), .address(address), .read(read),
   .write(write), .writedata(writedata), .readdata(readdata),
   .waitrequest(waitrequest), .timebase_clock_select(timebase_clock_select),
   .oscillator_ref_clock(oscillator_ref_clock), .pump_on(pump_on));
